// File: fc_pkg.sv
/*
  Package for the port 0 flow control register: offset, field positions, widths.
  Assumes a 32-bit register port with byte addresses and a single system clock.
*/
package fc_pkg;
  localparam int unsigned data_w = 32;
  localparam int unsigned addr_w = 12;
  localparam logic [addr_w-1:0] port0_flow_control_off = 12'h01a8;
  localparam int unsigned bit_backpressure = 6;
  localparam int unsigned bit_cur_duplex = 5;
  localparam int unsigned bit_cur_rx = 4;
  localparam int unsigned bit_cur_tx = 3;
  localparam int unsigned bit_rx_enable = 2;
  localparam int unsigned bit_tx_enable = 1;
  localparam int unsigned bit_manual = 0;
  localparam logic [data_w-1:0] zero_word = 32'h0000_0000;
endpackage

// File: fc_resolve.sv
/*
  Resolves the flow control in force on port 0 from manual enables and negotiation.
  Assumes all inputs are synchronous to clk; result is registered.
*/
`timescale 1ns/1ps
module fc_resolve (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic manual_flow_select,
  input wire logic rx_pause_enable,
  input wire logic tx_pause_enable,
  input wire logic autoneg_enable,
  input wire logic an_rx_pause,
  input wire logic an_tx_pause,
  input wire logic half_duplex,
  output logic cur_rx_ff,
  output logic cur_tx_ff
);
  wire logic use_manual;
  wire logic nxt_cur_rx;
  wire logic nxt_cur_tx;

  // Manual enables apply when selected or negotiation is off
  assign use_manual = manual_flow_select | ~autoneg_enable;
  // Pause only applies in full duplex
  function automatic logic in_force(input logic half, input logic sel, input logic man,
    input logic neg);
    return ~half & (sel ? man : neg);
  endfunction

  assign nxt_cur_rx = in_force(half_duplex, use_manual,
    rx_pause_enable, an_rx_pause);
  assign nxt_cur_tx = in_force(half_duplex, use_manual,
    tx_pause_enable, an_tx_pause);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_rx_ff <= 1'b0;
      cur_tx_ff <= 1'b0;
    end else if (clk_en) begin
      cur_rx_ff <= nxt_cur_rx;
      cur_tx_ff <= nxt_cur_tx;
    end
  end
endmodule // fc_resolve

// File: port0_manual_flow_control.sv
/*
  Port 0 manual flow control register with status readback and strap defaults.
  Assumes a synchronous single-cycle register port; straps valid at reset release.
*/
`timescale 1ns/1ps
module port0_manual_flow_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fc_pkg::addr_w-1:0] reg_addr,
  input wire logic [fc_pkg::data_w-1:0] reg_wdata,
  output logic [fc_pkg::data_w-1:0] reg_rdata_ff,
  input wire logic mac_mode,
  input wire logic strap_load,
  input wire logic backpressure_strap,
  input wire logic full_duplex_pause_strap,
  input wire logic manual_select_strap,
  input wire logic autoneg_enable,
  input wire logic an_rx_pause,
  input wire logic an_tx_pause,
  input wire logic half_duplex,
  output logic backpressure_enable_ff,
  output logic cur_duplex_ff,
  output logic cur_rx_pause_ff,
  output logic cur_tx_pause_ff
);
  import fc_pkg::*;

  logic init_done_ff;
  logic bp_ff;
  logic rx_en_ff;
  logic tx_en_ff;
  logic manual_ff;
  wire logic hit;
  wire logic wr_hit;
  wire logic load;
  wire logic manual_view;
  wire logic nxt_bp;
  wire logic nxt_rx_en;
  wire logic nxt_tx_en;
  wire logic nxt_manual;
  wire logic [data_w-1:0] nxt_rdata;

  assign hit = (reg_addr == port0_flow_control_off);
  assign wr_hit = reg_wr & hit;
  // Straps captured on first enabled edge after reset, or by loader
  assign load = ~init_done_ff | strap_load;
  assign manual_view = manual_ff | mac_mode;

  // Loader wins over a write landing in the same cycle
  function automatic logic pick_field(input logic ld, input logic strap, input logic wr,
    input logic wbit, input logic cur);
    return ld ? strap : (wr ? wbit : cur);
  endfunction

  assign nxt_bp = pick_field(load, backpressure_strap, wr_hit,
    reg_wdata[bit_backpressure], bp_ff);
  assign nxt_rx_en = pick_field(load, full_duplex_pause_strap, wr_hit,
    reg_wdata[bit_rx_enable], rx_en_ff);
  assign nxt_tx_en = pick_field(load, full_duplex_pause_strap, wr_hit,
    reg_wdata[bit_tx_enable], tx_en_ff);
  // MAC mode pins the bit high against writes and loader
  assign nxt_manual = mac_mode ? 1'b1 : pick_field(load, manual_select_strap, wr_hit,
    reg_wdata[bit_manual], manual_ff);

  // Reserved bits zero; no path to the advertisement register
  assign nxt_rdata = (reg_rd & hit) ?
    {zero_word[data_w-1:bit_backpressure+1], bp_ff, cur_duplex_ff, cur_rx_pause_ff,
     cur_tx_pause_ff, rx_en_ff, tx_en_ff, manual_view} : zero_word;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_done_ff <= 1'b0;
      bp_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
      manual_ff <= 1'b0;
      reg_rdata_ff <= zero_word;
      backpressure_enable_ff <= 1'b0;
      cur_duplex_ff <= 1'b0;
    end else if (clk_en) begin
      init_done_ff <= 1'b1;
      bp_ff <= nxt_bp;
      rx_en_ff <= nxt_rx_en;
      tx_en_ff <= nxt_tx_en;
      manual_ff <= nxt_manual;
      reg_rdata_ff <= nxt_rdata;
      backpressure_enable_ff <= nxt_bp;
      cur_duplex_ff <= half_duplex;
    end
  end

  fc_resolve u_resolve (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .manual_flow_select(manual_view),
    .rx_pause_enable(rx_en_ff),
    .tx_pause_enable(tx_en_ff),
    .autoneg_enable(autoneg_enable),
    .an_rx_pause(an_rx_pause),
    .an_tx_pause(an_tx_pause),
    .half_duplex(half_duplex),
    .cur_rx_ff(cur_rx_pause_ff),
    .cur_tx_ff(cur_tx_pause_ff)
  );

  property p_mac_manual;
    @(posedge clk) disable iff (reset)
    (clk_en && init_done_ff && reg_rd && hit && mac_mode) |=> reg_rdata_ff[bit_manual];
  endproperty
  a_mac_manual: assert property (p_mac_manual) else $error("manual not one in MAC mode");

  property p_mac_load;
    @(posedge clk) disable iff (reset)
    (clk_en && mac_mode) |=> manual_ff;
  endproperty
  a_mac_load: assert property (p_mac_load) else $error("loader changed manual in MAC");

  property p_reserved;
    @(posedge clk) disable iff (reset) reg_rdata_ff[data_w-1:bit_backpressure+1] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_strap_bp;
    @(posedge clk) disable iff (reset)
    (clk_en && strap_load) |=> bp_ff == $past(backpressure_strap);
  endproperty
  a_strap_bp: assert property (p_strap_bp) else $error("backpressure strap not loaded");

  property p_write_bp;
    @(posedge clk) disable iff (reset)
    (clk_en && !load && wr_hit) |=> backpressure_enable_ff == $past(reg_wdata[bit_backpressure]);
  endproperty
  a_write_bp: assert property (p_write_bp) else $error("backpressure write lost");

  property p_duplex;
    @(posedge clk) disable iff (reset) clk_en |=> cur_duplex_ff == $past(half_duplex);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex status wrong");

  property p_half_no_rx;
    @(posedge clk) disable iff (reset) (clk_en && half_duplex) |=> !cur_rx_pause_ff;
  endproperty
  a_half_no_rx: assert property (p_half_no_rx) else $error("rx pause in half duplex");

  property p_manual_tx;
    @(posedge clk) disable iff (reset)
    (clk_en && manual_view && !half_duplex) |=> cur_tx_pause_ff == $past(tx_en_ff);
  endproperty
  a_manual_tx: assert property (p_manual_tx) else $error("manual tx pause wrong");

  property p_an_rx;
    @(posedge clk) disable iff (reset)
    (clk_en && !manual_view && autoneg_enable && !half_duplex)
      |=> cur_rx_pause_ff == $past(an_rx_pause);
  endproperty
  a_an_rx: assert property (p_an_rx) else $error("negotiated rx pause wrong");

  property p_an_tx;
    @(posedge clk) disable iff (reset)
    (clk_en && !manual_view && autoneg_enable && !half_duplex)
      |=> cur_tx_pause_ff == $past(an_tx_pause);
  endproperty
  a_an_tx: assert property (p_an_tx) else $error("negotiated tx pause wrong");

  property p_no_an;
    @(posedge clk) disable iff (reset)
    (clk_en && !autoneg_enable && !half_duplex)
      |=> cur_rx_pause_ff == $past(rx_en_ff) && cur_tx_pause_ff == $past(tx_en_ff);
  endproperty
  a_no_an: assert property (p_no_an) else $error("enables not applied");

  property p_manual_rx;
    @(posedge clk) disable iff (reset)
    (clk_en && manual_view && !half_duplex) |=> cur_rx_pause_ff == $past(rx_en_ff);
  endproperty
  a_manual_rx: assert property (p_manual_rx) else $error("manual rx pause wrong");

  property p_half_no_tx;
    @(posedge clk) disable iff (reset) (clk_en && half_duplex) |=> !cur_tx_pause_ff;
  endproperty
  a_half_no_tx: assert property (p_half_no_tx) else $error("tx pause in half duplex");

  property p_write_pause;
    @(posedge clk) disable iff (reset)
    (clk_en && !load && wr_hit) |=> rx_en_ff == $past(reg_wdata[bit_rx_enable])
      && tx_en_ff == $past(reg_wdata[bit_tx_enable]);
  endproperty
  a_write_pause: assert property (p_write_pause) else $error("pause write lost");

  property p_write_manual;
    @(posedge clk) disable iff (reset)
    (clk_en && !load && wr_hit && !mac_mode) |=> manual_ff == $past(reg_wdata[bit_manual]);
  endproperty
  a_write_manual: assert property (p_write_manual) else $error("manual lost");

  property p_strap_fields;
    @(posedge clk) disable iff (reset)
    (clk_en && load) |=> rx_en_ff == $past(full_duplex_pause_strap)
      && tx_en_ff == $past(full_duplex_pause_strap);
  endproperty
  a_strap_fields: assert property (p_strap_fields) else $error("pause strap lost");

  property p_strap_manual;
    @(posedge clk) disable iff (reset)
    (clk_en && load && !mac_mode) |=> manual_ff == $past(manual_select_strap);
  endproperty
  a_strap_manual: assert property (p_strap_manual) else $error("manual strap lost");

  property p_idle_rdata;
    @(posedge clk) disable iff (reset)
    (clk_en && !(reg_rd && hit)) |=> reg_rdata_ff == zero_word;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("stale read data");

  property p_freeze;
    @(posedge clk) disable iff (reset)
    !clk_en |=> $stable(bp_ff) && $stable(manual_ff) && $stable(cur_rx_pause_ff)
      && $stable(cur_tx_pause_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  c_write: cover property (@(posedge clk) disable iff (reset) clk_en && wr_hit);
  c_mac_write: cover property (@(posedge clk) disable iff (reset) clk_en && wr_hit && mac_mode);
  c_loader: cover property (@(posedge clk) disable iff (reset) clk_en && strap_load);
  c_an: cover property (@(posedge clk) disable iff (reset) cur_rx_pause_ff && !manual_view);
endmodule // port0_manual_flow_control

// File: tb_port0_manual_flow_control.sv
/*
  Self-checking bench for the port 0 flow control register: random rounds of
  writes, strap reloads, MAC mode, negotiation and duplex changes, then readback.
  Assumes fc_pkg and the design files are compiled first; assertions live in them.
*/
`timescale 1ns/1ps
module tb_port0_manual_flow_control;
  import fc_pkg::*;
  logic clk, reset, clk_en, reg_wr, reg_rd, mac_mode, strap_load;
  logic [addr_w-1:0] reg_addr;
  logic [data_w-1:0] reg_wdata, reg_rdata_ff, r, w, e, g;
  logic backpressure_strap, full_duplex_pause_strap, manual_select_strap;
  logic autoneg_enable, an_rx_pause, an_tx_pause, half_duplex;
  logic backpressure_enable_ff, cur_duplex_ff, cur_rx_pause_ff, cur_tx_pause_ff;
  logic bp, rxe, txe, man, man_x, hit, ld;
  logic [31:0] seed = 32'h8a46_b47f;
  int n_errors = 0;
  int checked = 0;

  port0_manual_flow_control port0_manual_flow_control_inst (.clk(clk), .reset(reset),
    .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .mac_mode(mac_mode),
    .strap_load(strap_load), .backpressure_strap(backpressure_strap),
    .full_duplex_pause_strap(full_duplex_pause_strap),
    .manual_select_strap(manual_select_strap), .autoneg_enable(autoneg_enable),
    .an_rx_pause(an_rx_pause), .an_tx_pause(an_tx_pause), .half_duplex(half_duplex),
    .backpressure_enable_ff(backpressure_enable_ff), .cur_duplex_ff(cur_duplex_ff),
    .cur_rx_pause_ff(cur_rx_pause_ff), .cur_tx_pause_ff(cur_tx_pause_ff));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected register word from the bench's own field model
  function automatic logic [31:0] exp_word();
    logic m, cr, ct;
    m = mac_mode | man;
    cr = half_duplex ? 1'b0 : ((m | !autoneg_enable) ? rxe : an_rx_pause);
    ct = half_duplex ? 1'b0 : ((m | !autoneg_enable) ? txe : an_tx_pause);
    return {zero_word[31:7], bp, half_duplex, cr, ct, rxe, txe, m};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [addr_w-1:0] a, input logic [31:0] d, input logic l,
                    input logic en);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    strap_load = l;
    clk_en = en;
    @(negedge clk);
    reg_wr = 1'b0;
    strap_load = 1'b0;
    clk_en = 1'b1;
  endtask

  task automatic rd(input logic [addr_w-1:0] a, input logic [31:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata_ff, exp);
    @(negedge clk);
    chk(reg_rdata_ff, zero_word);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    n_errors++;
    wrap_up();
  end

  initial begin
    {reset, reg_wr, reg_rd, strap_load, mac_mode, autoneg_enable} = 6'h20;
    {an_rx_pause, an_tx_pause, half_duplex, clk_en} = 4'h1;
    {backpressure_strap, full_duplex_pause_strap, manual_select_strap} = 3'h6;
    reg_addr = port0_flow_control_off;
    reg_wdata = zero_word;
    {bp, rxe, txe, man, man_x} = 5'h1c;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    rd(port0_flow_control_off, exp_word());
    for (int i = 0; i < 80; i++) begin
      r = xs();
      w = xs();
      mac_mode = r[8] & r[9];
      {autoneg_enable, an_rx_pause, an_tx_pause} = r[12:10];
      half_duplex = r[13] & r[14];
      {backpressure_strap, full_duplex_pause_strap, manual_select_strap} = r[17:15];
      hit = r[3:2] != 2'h0;
      ld = r[7:6] == 2'h0;
      if (man_x && !mac_mode) begin
        {hit, ld, r[4]} = 3'h5;
      end
      // Host copies external negotiation results into the enables
      if (mac_mode) w[2:1] = {an_rx_pause, an_tx_pause};
      wr(hit ? port0_flow_control_off : 12'h01a4, w, ld, ld | r[4] | r[5]);
      if (ld) begin
        {bp, rxe, txe} = {backpressure_strap, {2{full_duplex_pause_strap}}};
        if (!mac_mode) man = manual_select_strap;
      end else if (hit && (r[4] | r[5])) begin
        {bp, rxe, txe} = {w[6], w[2], w[1]};
        if (!mac_mode) man = w[0];
      end
      man_x = mac_mode | (man_x & !((hit && (r[4] | r[5])) || ld));
      repeat (3) @(negedge clk);
      e = exp_word();
      g = {28'h000_0000, backpressure_enable_ff, cur_duplex_ff, cur_rx_pause_ff,
           cur_tx_pause_ff};
      chk(g, {28'h000_0000, e[6:3]});
      rd(port0_flow_control_off, exp_word());
      rd(12'h01ac, zero_word);
    end
    wrap_up();
  end
endmodule // tb_port0_manual_flow_control
